/* File: design/can_msg_buf.sv */
// Purpose: CAN message storage: three transmit slots, two-stage receive path, pin engine
// Assumes: Bus frames are 1 start bit plus header and data, unstuffed, no CRC or ack slot
// Notes: Host side is plain ports; only the foreground stage is visible to it
module can_msg_buf
  import can_buf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic bus_receive_pin,
  output logic bus_transmit_pin,
  input wire logic tx_load,
  input wire logic [1:0] tx_sel,
  input wire frame_t tx_frame,
  input wire logic [PRIO_W-1:0] tx_prio,
  output logic [NUM_TX-1:0] tx_empty,
  output logic tx_done,
  output frame_t rx_frame,
  output logic receive_full_flag,
  input wire logic rx_clear,
  input wire logic rx_irq_en,
  output logic rx_event,
  output logic rx_irq,
  input wire logic overrun_en,
  output logic overrun,
  input wire logic loopback,
  input wire logic [ID_BITS-1:0] acc_code,
  input wire logic [ID_BITS-1:0] acc_mask
);

  logic rx_level;
  frame_t slot_frame [NUM_TX];
  logic [PRIO_W-1:0] slot_prio [NUM_TX];
  logic [NUM_TX-1:0] slot_pending;
  logic [NUM_TX-1:0] slot_done;
  logic [NUM_TX-1:0] empty_ff;

  // Receive pin enters through three synchroniser flops and a filter flop
  pin_sync u_rx_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .pin_in(bus_receive_pin), // RL1
    .level(rx_level)
  );

  // Three identical transmit slots
  for (genvar i = 0; i < NUM_TX; i++)
  begin : g_slot
    tx_slot u_slot (
      .mclk(mclk),
      .rst_n(rst_n),
      .load(tx_load && (tx_sel == 2'(i))), // RL7
      .load_frame(tx_frame),
      .load_prio(tx_prio),
      .done(slot_done[i]),
      .frame(slot_frame[i]),
      .prio(slot_prio[i]),
      .pending(slot_pending[i])
    );
  end

  // Pick the pending slot with the lowest priority value; lower index wins ties
  logic [1:0] best_sel;
  logic any_pending;
  always_comb
  begin
    best_sel = 2'h0;
    any_pending = 1'b0;
    for (int i = 0; i < NUM_TX; i++)
    begin
      if (slot_pending[i] && (!any_pending || slot_prio[i] < slot_prio[best_sel]))
      begin
        best_sel = 2'(i); // RL6
        any_pending = 1'b1;
      end
    end
  end

  // Engine state
  eng_state_t state_ff, nxt_state;
  logic [TIMER_W-1:0] timer_ff, nxt_timer;
  logic [CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic [3:0] gap_cnt_ff, nxt_gap_cnt;
  logic [1:0] sel_ff, nxt_sel;
  logic txpin_ff, nxt_txpin;
  frame_t order_ff, nxt_order;
  logic own_ff, nxt_own;
  logic done_pulse_ff, nxt_done_pulse;
  logic end_frame;
  frame_t tx_order;
  logic [3:0] dlc_c;
  logic [CNT_W-1:0] total_bits;

  assign tx_order = to_order(slot_frame[sel_ff]);

  // Bit engine: gap wait, idle, transmit with arbitration, receive
  always_comb
  begin
    nxt_state = state_ff;
    nxt_timer = timer_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_gap_cnt = gap_cnt_ff;
    nxt_sel = sel_ff;
    nxt_txpin = txpin_ff;
    nxt_order = order_ff;
    nxt_own = own_ff;
    nxt_done_pulse = 1'b0;
    end_frame = 1'b0;
    dlc_c = 4'h0;
    total_bits = HDR_CNT;
    nxt_timer = (timer_ff == BIT_LAST) ? '0 : timer_ff + 1'b1;
    case (state_ff)
      st_gap:
      begin
        nxt_txpin = 1'b1; // RL2
        if (timer_ff == SAMPLE_AT)
        begin
          if (!rx_level)
            nxt_gap_cnt = 4'h0;
          else if (gap_cnt_ff == GAP_BITS - 4'h1)
          begin
            nxt_state = st_idle; // RL15
            nxt_gap_cnt = 4'h0;
          end
          else
            nxt_gap_cnt = gap_cnt_ff + 4'h1;
        end
      end
      st_idle:
      begin
        nxt_timer = '0;
        nxt_bit_cnt = '0;
        nxt_order = '0;
        if (any_pending)
        begin
          nxt_state = st_tx; // RL5
          nxt_sel = best_sel; // RL6
          nxt_txpin = 1'b0; // RL2
          nxt_own = 1'b1;
        end
        else if (!rx_level)
        begin
          nxt_state = st_rx;
          nxt_timer = TIMER_W'(1);
          nxt_own = 1'b0;
        end
      end
      st_tx, st_rx:
      begin
        if (timer_ff == SAMPLE_AT && bit_cnt_ff != '0)
        begin
          nxt_order[FRAME_BITS - 32'(bit_cnt_ff)] = rx_level;
          // Arbitration only within the identifier; losing turns us into a receiver
          if (state_ff == st_tx && txpin_ff && !rx_level && bit_cnt_ff <= CNT_W'(ID_BITS))
          begin
            nxt_state = st_rx; // RL5
            nxt_own = 1'b0;
            nxt_txpin = 1'b1;
          end
          dlc_c = (nxt_order[DLC_ORDER_LSB +: 4] > MAX_DLC) ? MAX_DLC
                  : nxt_order[DLC_ORDER_LSB +: 4]; // RL4
          total_bits = HDR_CNT + {dlc_c, 3'h0};
          if (bit_cnt_ff >= HDR_CNT && bit_cnt_ff == total_bits)
          begin
            end_frame = 1'b1;
            nxt_state = st_gap;
            nxt_gap_cnt = 4'h0;
            nxt_txpin = 1'b1;
            nxt_done_pulse = own_ff && state_ff == st_tx;
          end
        end
        else if (timer_ff == BIT_LAST)
        begin
          nxt_bit_cnt = bit_cnt_ff + 1'b1;
          if (state_ff == st_tx)
            nxt_txpin = tx_order[FRAME_BITS - 1 - 32'(bit_cnt_ff)]; // RL2
        end
      end
      default:
        nxt_state = st_gap;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff <= st_gap;
      timer_ff <= '0;
      bit_cnt_ff <= '0;
      gap_cnt_ff <= 4'h0;
      sel_ff <= 2'h0;
      txpin_ff <= 1'b1;
      order_ff <= '0;
      own_ff <= 1'b0;
      done_pulse_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      timer_ff <= nxt_timer;
      bit_cnt_ff <= nxt_bit_cnt;
      gap_cnt_ff <= nxt_gap_cnt;
      sel_ff <= nxt_sel;
      txpin_ff <= nxt_txpin;
      order_ff <= nxt_order;
      own_ff <= nxt_own;
      done_pulse_ff <= nxt_done_pulse;
    end
  end

  // Slot release the cycle the completion pulse is registered
  always_comb
  begin
    slot_done = '0;
    if (done_pulse_ff)
      slot_done[sel_ff] = 1'b1;
  end

  // Receive stages; background is never driven onto a port
  frame_t bg_ff, nxt_bg;
  frame_t fg_ff, nxt_fg;
  logic bg_full_ff, nxt_bg_full;
  logic full_ff, nxt_full;
  logic event_ff, nxt_event;
  logic irq_ff, nxt_irq;
  logic ovr_ff, nxt_ovr;
  frame_t got_lay;
  logic [ID_BITS-1:0] eff_mask;
  logic hit;

  assign got_lay = to_layout(nxt_order);
  assign eff_mask = got_lay[IDE_POS] ? acc_mask : (acc_mask | STD_IGNORE); // RL3
  assign hit = ((got_lay[FRAME_BITS-1:ID_LSB] ^ acc_code) & ~eff_mask) == '0; // RL19

  // Frame landing, ping-pong copy and host clear
  always_comb
  begin
    nxt_bg = bg_ff;
    nxt_fg = fg_ff;
    nxt_bg_full = bg_full_ff;
    nxt_full = full_ff;
    nxt_event = 1'b0;
    nxt_ovr = 1'b0;
    if (rx_clear)
      nxt_full = 1'b0; // RL16
    // Copy one cycle after landing, only into a free foreground
    if (bg_full_ff && !full_ff)
    begin
      nxt_fg = bg_ff; // RL13
      nxt_full = 1'b1; // RL12
      nxt_event = 1'b1; // RL11
      nxt_bg_full = 1'b0;
    end
    if (end_frame)
    begin
      if (own_ff && !loopback)
      begin
        if (!bg_full_ff)
          nxt_bg = got_lay; // RL18
      end
      else if (bg_full_ff && full_ff)
        nxt_ovr = overrun_en; // RL17
      else if (!nxt_bg_full || !bg_full_ff)
      begin
        nxt_bg = got_lay; // RL10
        nxt_bg_full = hit; // RL19
      end
    end
    nxt_irq = nxt_full && rx_irq_en; // RL14
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bg_ff <= '0;
      fg_ff <= '0;
      bg_full_ff <= 1'b0;
      full_ff <= 1'b0;
      event_ff <= 1'b0;
      irq_ff <= 1'b0;
      ovr_ff <= 1'b0;
      empty_ff <= '1;
    end
    else
    begin
      bg_ff <= nxt_bg;
      fg_ff <= nxt_fg;
      bg_full_ff <= nxt_bg_full;
      full_ff <= nxt_full;
      event_ff <= nxt_event;
      irq_ff <= nxt_irq;
      ovr_ff <= nxt_ovr;
      empty_ff <= ~slot_pending;
    end
  end

  // Outputs straight from flops
  assign bus_transmit_pin = txpin_ff;
  assign tx_empty = empty_ff;
  assign tx_done = done_pulse_ff;
  assign rx_frame = fg_ff; // RL8 RL9
  assign receive_full_flag = full_ff;
  assign rx_event = event_ff;
  assign rx_irq = irq_ff;
  assign overrun = ovr_ff;

  sequence s_gap_done;
    state_ff == st_gap && timer_ff == SAMPLE_AT && rx_level && gap_cnt_ff == GAP_BITS - 4'h1;
  endsequence

  a_gap_ready: assert property (@(posedge mclk) disable iff (!rst_n)
    s_gap_done |=> state_ff == st_idle) // RL15
    else $error("engine not idle after closing gap");

  a_idle_recessive: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == st_gap || state_ff == st_idle) && !$past(state_ff == st_idle)
      |-> bus_transmit_pin) // RL2
    else $error("transmit pin dominant outside a frame");

  a_fg_stable: assert property (@(posedge mclk) disable iff (!rst_n)
    full_ff |=> $stable(fg_ff)) // RL20
    else $error("foreground changed while full");

  a_copy_event: assert property (@(posedge mclk) disable iff (!rst_n)
    (bg_full_ff && !full_ff) |=> (full_ff && rx_event && fg_ff == $past(bg_ff))) // RL12
    else $error("background not copied forward");

  a_irq_mask: assert property (@(posedge mclk) disable iff (!rst_n)
    rx_irq |-> $past(rx_irq_en) && $past(nxt_full)) // RL14
    else $error("interrupt raised while masked");

  // A frame already waiting in the background keeps its mark; an own frame with loopback clear may not set it
  a_own_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
    (end_frame && own_ff && !loopback && !bg_full_ff) |=> !bg_full_ff [*2]) // RL18
    else $error("own frame queued for foreground");

  a_overrun_cause: assert property (@(posedge mclk) disable iff (!rst_n)
    overrun |-> $past(bg_full_ff && full_ff && end_frame && overrun_en)) // RL17
    else $error("overrun without both stages full");

  // Judged against the slots pending when the choice was made; a later load may not count
  a_prio_pick: assert property (@(posedge mclk) disable iff (!rst_n)
    (state_ff == st_idle && any_pending) |=> state_ff == st_tx
      && (!$past(slot_pending[0]) || slot_prio[sel_ff] <= $past(slot_prio[0]))
      && (!$past(slot_pending[1]) || slot_prio[sel_ff] <= $past(slot_prio[1]))
      && (!$past(slot_pending[2]) || slot_prio[sel_ff] <= $past(slot_prio[2]))) // RL6
    else $error("lower priority slot chosen");

  a_miss_no_copy: assert property (@(posedge mclk) disable iff (!rst_n)
    (end_frame && !own_ff && !hit && !(bg_full_ff && full_ff)) |=> !bg_full_ff) // RL19
    else $error("filter miss marked for copy");

endmodule // can_msg_buf

/* File: design/can_buf_pkg.sv */
// Purpose: Shared constants, types and byte-order helpers for the CAN buffering block
// Assumes: 200 MHz mclk, 1 Mbit/s bus, no bit stuffing or CRC on the wire
// Notes: Frame image is 13 bytes: 4 identifier, 8 data, 1 length (byte 0 at the top)
// Behaviour
// RL1: Only one receive and one transmit pin
// RL2: Transmit pin low dominant, high recessive
// RL3: Standard and extended identifier frames both handled
// RL4: Data field carries zero to eight bytes
// RL5: Rearbitrate right after previous frame ends
// RL6: Lowest priority value among pending sent first
// RL7: Three independent transmit slots
// RL8: Two receive stages behind one host window
// RL9: Background stage internal, host sees foreground only
// RL10: Each receive stage holds thirteen bytes
// RL11: Full flag means accepted frame in foreground
// RL12: Good frame copied forward, flag set, event
// RL13: Copy only while full flag is clear
// RL14: Interrupt only when unmasked; flag pollable
// RL15: Ready for next frame after the gap
// RL16: Host reads foreground then clears flag
// RL17: Both stages full: discard, overrun, stay active
// RL18: Own frames reach background only, no event; with loopback set the code copies them forward with an event
// RL19: Copy only on acceptance filter hit
// RL20: Foreground stable while full flag set
package can_buf_pkg;

  localparam int FRAME_BYTES = 13;
  localparam int FRAME_BITS = FRAME_BYTES * 8;
  localparam int ID_BYTES = 4;
  localparam int ID_BITS = ID_BYTES * 8;
  localparam int HDR_BITS = ID_BITS + 8;
  localparam int DLC_BYTE = 12;
  localparam int NUM_TX = 3;
  localparam int PRIO_W = 8;
  localparam int CNT_W = 7;
  localparam int TIMER_W = 8;

  // Bit timing derived from the bus rate
  localparam int CLK_PERIOD_NS = 5;
  localparam int BIT_TIME_NS = 1000;
  localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [TIMER_W-1:0] BIT_LAST = TIMER_W'(BIT_CYCLES - 1);
  localparam logic [TIMER_W-1:0] SAMPLE_AT = TIMER_W'(BIT_CYCLES / 2);

  // Recessive bits that close a frame (end field plus gap)
  localparam logic [3:0] GAP_BITS = 4'ha;
  localparam logic [3:0] MAX_DLC = 4'h8;
  localparam logic [CNT_W-1:0] HDR_CNT = CNT_W'(HDR_BITS);

  // Field positions in the transfer order and the layout image
  localparam int DLC_ORDER_LSB = FRAME_BITS - HDR_BITS;
  localparam int IDE_POS = FRAME_BITS - 13;
  localparam int ID_LSB = FRAME_BITS - ID_BITS;
  localparam logic [ID_BITS-1:0] STD_IGNORE = 32'h0000ffff;

  typedef logic [FRAME_BITS-1:0] frame_t;
  typedef enum logic [1:0] {st_gap, st_idle, st_tx, st_rx} eng_state_t;

  // Layout byte sent as the b-th byte: identifier, length, then data
  function automatic int layout_byte(input int b);
    if (b < ID_BYTES) return b;
    if (b == ID_BYTES) return DLC_BYTE;
    return b - 1;
  endfunction

  function automatic frame_t to_order(input frame_t lay);
    frame_t o;
    o = '0;
    for (int b = 0; b < FRAME_BYTES; b++)
      o[FRAME_BITS-1-8*b -: 8] = lay[FRAME_BITS-1-8*layout_byte(b) -: 8];
    return o;
  endfunction

  function automatic frame_t to_layout(input frame_t o);
    frame_t lay;
    lay = '0;
    for (int b = 0; b < FRAME_BYTES; b++)
      lay[FRAME_BITS-1-8*layout_byte(b) -: 8] = o[FRAME_BITS-1-8*b -: 8];
    return lay;
  endfunction

endpackage

/* File: design/pin_sync.sv */
// Purpose: Three-stage synchroniser for the receive pin
// Assumes: Pin idles recessive (high)
// Notes: Output moves only when stages two and three agree
module pin_sync
  import can_buf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level
);

  logic s1_ff, s2_ff, s3_ff, level_ff;
  logic nxt_level;

  // Filter: a one-sample glitch past stage two never reaches the engine
  always_comb
  begin
    nxt_level = level_ff;
    if (s2_ff == s3_ff)
      nxt_level = s3_ff;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      level_ff <= 1'b1;
    end
    else
    begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

  a_sync_agree: assert property (@(posedge mclk) disable iff (!rst_n)
    (s2_ff == s3_ff) |=> (level_ff == $past(s3_ff)))
    else $error("synchronised level ignored agreeing stages");

endmodule // pin_sync

/* File: design/tx_slot.sv */
// Purpose: One transmit slot: frame image, local priority, pending mark
// Assumes: Load and done come from logic on mclk
// Notes: A load while pending is ignored so a queued frame is never torn
module tx_slot
  import can_buf_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic load,
  input wire frame_t load_frame,
  input wire logic [PRIO_W-1:0] load_prio,
  input wire logic done,
  output frame_t frame,
  output logic [PRIO_W-1:0] prio,
  output logic pending
);

  frame_t frame_ff, nxt_frame;
  logic [PRIO_W-1:0] prio_ff, nxt_prio;
  logic pending_ff, nxt_pending;

  // Slot fill and release
  always_comb
  begin
    nxt_frame = frame_ff;
    nxt_prio = prio_ff;
    nxt_pending = pending_ff;
    if (done)
      nxt_pending = 1'b0;
    else if (load && !pending_ff)
    begin
      nxt_frame = load_frame; // RL7
      nxt_prio = load_prio;
      nxt_pending = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_ff <= '0;
      prio_ff <= '0;
      pending_ff <= 1'b0;
    end
    else
    begin
      frame_ff <= nxt_frame;
      prio_ff <= nxt_prio;
      pending_ff <= nxt_pending;
    end
  end

  assign frame = frame_ff;
  assign prio = prio_ff;
  assign pending = pending_ff;

  a_slot_load: assert property (@(posedge mclk) disable iff (!rst_n)
    (load && !pending_ff && !done) |=> (pending_ff && frame_ff == $past(load_frame))) // RL7
    else $error("empty slot did not take a load");

endmodule // tx_slot

/* File: bench/can_node_model.sv */
// Purpose: Far-side bus node: shared wired-AND line, sends frames on demand
// Assumes: Bit time of BIT_CYCLES mclk, unstuffed frames as the engine expects
// Notes: Released line reads recessive, as a terminated bus would
module can_node_model
  import can_buf_pkg::*;
(
  input wire logic mclk,
  input wire logic tx_pin,
  output logic line
);
  timeunit 1ns;
  timeprecision 1ps;

  logic drive;

  // Dominant (low) from either node wins on the shared line
  assign line = tx_pin & drive;

  initial drive = 1'b1;

  // One bit held a whole bit time, changed on the falling edge
  task automatic put_bit(input logic b);
    @(negedge mclk);
    drive = b;
    repeat (BIT_CYCLES - 1) @(negedge mclk);
  endtask

  // Start bit, identifier, length, data, then a recessive gap
  task automatic send(input frame_t f);
    int n;
    n = (f[3:0] > 4'h8) ? 8 : int'(f[3:0]);
    put_bit(1'b0);
    for (int i = 0; i < 32; i++)
      put_bit(f[103 - i]);
    for (int i = 0; i < 8; i++)
      put_bit(f[7 - i]);
    for (int i = 0; i < 8 * n; i++)
      put_bit(f[71 - i]);
    for (int i = 0; i < 12; i++)
      put_bit(1'b1);
  endtask
endmodule // can_node_model

/* File: bench/can_message_buffering_test.sv */
// Purpose: Self-checking bench for the CAN message buffering block
// Assumes: Far node is idle whenever the block transmits
// Notes: Frames kept short so the whole run fits the cycle budget
module can_message_buffering_test
  import can_buf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk, rst_n, tx_load, rx_clear, rx_irq_en, overrun_en, loopback;
  logic bus_transmit_pin, line, tx_done, receive_full_flag, rx_event, rx_irq, overrun;
  logic [1:0] tx_sel;
  frame_t tx_frame, rx_frame;
  logic [PRIO_W-1:0] tx_prio;
  logic [NUM_TX-1:0] tx_empty;
  logic [ID_BITS-1:0] acc_code, acc_mask;
  int fail_count, n_tests, ev_cnt, ov_cnt, done_cnt, cyc;
  logic [31:0] ids[$];
  int starts[$];

  can_msg_buf dut (.mclk(mclk), .rst_n(rst_n), .bus_receive_pin(line),
    .bus_transmit_pin(bus_transmit_pin), .tx_load(tx_load), .tx_sel(tx_sel),
    .tx_frame(tx_frame), .tx_prio(tx_prio), .tx_empty(tx_empty), .tx_done(tx_done),
    .rx_frame(rx_frame), .receive_full_flag(receive_full_flag), .rx_clear(rx_clear),
    .rx_irq_en(rx_irq_en), .rx_event(rx_event), .rx_irq(rx_irq),
    .overrun_en(overrun_en), .overrun(overrun), .loopback(loopback),
    .acc_code(acc_code), .acc_mask(acc_mask));

  can_node_model node (.mclk(mclk), .tx_pin(bus_transmit_pin), .line(line));

  // Clock
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // Pulse counters, so one-cycle outputs are never missed
  always @(posedge mclk)
  begin
    cyc++;
    ev_cnt += int'(rx_event === 1'b1);
    ov_cnt += int'(overrun === 1'b1);
    done_cnt += int'(tx_done === 1'b1);
  end

  // Line decoder: identifier and start cycle of each frame
  initial
  begin
    logic [39:0] hdr;
    forever
    begin
      wait (line === 1'b0);
      starts.push_back(cyc);
      repeat (BIT_CYCLES / 2) @(posedge mclk);
      for (int i = 0; i < 40; i++)
      begin
        repeat (BIT_CYCLES) @(posedge mclk);
        hdr = {hdr[38:0], line};
      end
      ids.push_back(hdr[39:8]);
      repeat (BIT_CYCLES * 8 * ((hdr[3:0] > 4'h8) ? 8 : int'(hdr[3:0]))) @(posedge mclk);
      wait (line === 1'b1);
    end
  end

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("comparisons=%0d mismatches=%0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Strobe left high so back-to-back loads never toggle it in one step
  task automatic load(input logic [1:0] s, input logic [31:0] id, input logic [7:0] p);
    tx_sel = s;
    tx_frame = {id, 64'h0, 8'h00};
    tx_prio = p;
    tx_load = 1'b1;
    @(negedge mclk);
  endtask

  task automatic clear_flag;
    rx_clear = 1'b1;
    @(negedge mclk);
    rx_clear = 1'b0;
    repeat (3) @(negedge mclk);
  endtask

  task automatic check_reset;
    check(tx_empty, 3'h7);
    check(bus_transmit_pin, 1'b1);
    check(receive_full_flag, 1'b0);
  endtask

  // Fill both stages, overrun, then release and see the queued frame
  task automatic rx_path;
    frame_t f1, f2;
    f1 = {32'h123c5678, 64'h0102030405060708, 8'h08};
    f2 = {32'h2a400000, 8'h55, 56'h0, 8'h01};
    node.send(f1);
    check(receive_full_flag, 1'b1);
    check(rx_frame, f1);
    check(ev_cnt, 1);
    check(rx_irq, 1'b1);
    rx_irq_en = 1'b0;
    node.send(f2);
    check(rx_frame, f1);
    check(ev_cnt, 1);
    node.send({32'h7f080000, 64'h0, 8'h00});
    check(ov_cnt, 1);
    check(rx_frame, f1);
    clear_flag();
    check(receive_full_flag, 1'b1);
    check(rx_frame[103:72], f2[103:72]);
    check(rx_frame[71:64], 8'h55);
    check(rx_frame[7:0], 8'h01);
    check(rx_irq, 1'b0);
    clear_flag();
    check(receive_full_flag, 1'b0);
  endtask

  // A frame whose identifier differs from the code must not pass a filter that masks no bit
  task automatic filter_miss;
    acc_mask = 32'h0;
    node.send({32'h7f080000, 64'h0, 8'h00});
    check(receive_full_flag, 1'b0);
    check(ev_cnt, 2);
    acc_mask = 32'hffffffff;
  endtask

  // First slot starts at once; the other two must follow by priority
  task automatic tx_queue;
    ids.delete();
    starts.delete();
    load(2'd0, 32'h11000000, 8'h30);
    load(2'd1, 32'h22000000, 8'h20);
    load(2'd2, 32'h33000000, 8'h10);
    tx_load = 1'b0;
    @(negedge mclk);
    check(tx_empty, 3'h0);
    for (int i = 0; i < 200 * BIT_CYCLES && done_cnt < 3; i++)
      @(negedge mclk);
    repeat (3) @(negedge mclk);
    check(done_cnt, 3);
    check(tx_empty, 3'h7);
    check(ids.size(), 3);
    if (ids.size() == 3)
    begin
      check(ids[0], 32'h11000000);
      check(ids[1], 32'h33000000);
      check(ids[2], 32'h22000000);
      check(starts[2] - starts[1] <= 53 * BIT_CYCLES, 1'b1);
    end
    check(ev_cnt, 2);
  endtask

  // Loop-back: an own frame is taken in like any other and reaches the host
  task automatic loop_back;
    frame_t f;
    f = {32'h44000000, 64'h0, 8'h00};
    loopback = 1'b1;
    load(2'd0, f[103:72], 8'h00);
    tx_load = 1'b0;
    for (int i = 0; i < 60 * BIT_CYCLES && done_cnt < 4; i++)
      @(negedge mclk);
    repeat (3) @(negedge mclk);
    check(done_cnt, 4);
    check(receive_full_flag, 1'b1);
    check(rx_frame, f);
    check(ev_cnt, 3);
    loopback = 1'b0;
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    tx_load = 1'b0;
    tx_sel = 2'h0;
    tx_frame = '0;
    tx_prio = 8'h00;
    rx_clear = 1'b0;
    rx_irq_en = 1'b1;
    overrun_en = 1'b1;
    loopback = 1'b0;
    acc_code = 32'h0;
    acc_mask = 32'hffffffff;
    repeat (6) @(negedge mclk);
    check_reset();
    rst_n = 1'b1;
    repeat (11 * BIT_CYCLES) @(negedge mclk);
    rx_path();
    filter_miss();
    tx_queue();
    loop_back();
    end_sim();
  end

  // Watchdog just past the expected run of about 97500 cycles
  initial
  begin
    repeat (100000) @(posedge mclk);
    fail_count++;
    end_sim();
  end
endmodule // can_message_buffering_test
